// ---- hdl/ovf_pkg.sv ----
package ovf_pkg;

  // Command code of the response word on the management interface
  localparam logic [7:0] CMD_OV_RESPONSE = 8'h41;
  // Command code of the delay-unit register kept outside this block
  localparam logic [7:0] CMD_DELAY_UNIT  = 8'hd2;

  // Response word layout
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  // Power-on value of the response word: disable and do not retry
  localparam logic [7:0] OV_RESPONSE_RESET = 8'h80;

  // Response codes
  localparam logic [1:0] RESP_IGNORE    = 2'h0;
  localparam logic [1:0] RESP_DELAY     = 2'h1;
  localparam logic [1:0] RESP_DISABLE   = 2'h2;
  localparam logic [1:0] RESP_HOLD_OFF  = 2'h3;

  // Retry codes
  localparam logic [2:0] RETRY_NONE       = 3'h0;
  localparam logic [2:0] RETRY_CONTINUOUS = 3'h7;

  // Width of the delay-unit length, in clock cycles
  localparam int UNIT_W = 16;
  localparam int MULT_W = 8;

  // Controller states
  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,  // Converting, no fault action pending
    ST_DELAY = 3'b001,  // Fault seen, still converting for the delay
    ST_HOLD  = 3'b010,  // Off while the fault lasts
    ST_WAIT  = 3'b011,  // Off, waiting for the next restart
    ST_TRY   = 3'b100,  // Restart attempt in progress
    ST_LATCH = 3'b101,  // Off until the fault is cleared
    ST_OFF   = 3'b110   // Commanded off
  } ovf_state_e;

  // Delay multiplier: two raised to the delay code
  function automatic logic [MULT_W-1:0] delay_mult(input logic [2:0] code);
    delay_mult = MULT_W'(1) << code;
  endfunction : delay_mult

  // Output stage is driven in these states only
  function automatic logic state_drives(input ovf_state_e st);
    state_drives = (st == ST_RUN) || (st == ST_DELAY) || (st == ST_TRY);
  endfunction : state_drives

endpackage : ovf_pkg

// ---- hdl/ovf_delay_timer.sv ----
`timescale 1ns/1ps
module ovf_delay_timer (
  input  wire logic                        clock,       // System clock
  input  wire logic                        nrst,        // Async reset, active low
  input  wire logic                        start,       // Restart the count
  input  wire logic [ovf_pkg::UNIT_W-1:0]  unit_cycles, // Cycles per delay unit
  input  wire logic [2:0]                  code,        // Delay code
  output logic                             done         // One-cycle end pulse
);
  import ovf_pkg::*;

  logic                busy_ff;
  logic [UNIT_W-1:0]   pre_ff;
  logic [MULT_W-1:0]   units_ff;
  logic [2:0]          code_ff;
  logic [UNIT_W-1:0]   unit_ff;
  wire  logic [UNIT_W-1:0] unit_last;
  wire  logic              unit_tick;
  wire  logic              last_unit;

  // A zero unit length would never tick, so it counts as one cycle
  assign unit_last = (unit_ff == '0) ? '0 : unit_ff - UNIT_W'(1);
  assign unit_tick = busy_ff && (pre_ff == unit_last);
  assign last_unit = (units_ff == delay_mult(code_ff) - MULT_W'(1));

  // Prescaler makes the unit tick, unit counter makes the multiple
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_ff  <= 1'b0;
      pre_ff   <= '0;
      units_ff <= '0;
      code_ff  <= '0;
      unit_ff  <= '0;
      done     <= 1'b0;
    end else if (start) begin
      busy_ff  <= 1'b1;
      pre_ff   <= '0;
      units_ff <= '0;
      code_ff  <= code;         // Settings frozen so a write cannot stretch a running wait
      unit_ff  <= unit_cycles;
      done     <= 1'b0;
    end else begin
      done <= unit_tick && last_unit;
      if (unit_tick) begin
        pre_ff   <= '0;
        units_ff <= units_ff + MULT_W'(1);
        if (last_unit) begin
          busy_ff <= 1'b0;
        end
      end else if (busy_ff) begin
        pre_ff <= pre_ff + UNIT_W'(1);
      end
    end
  end

endmodule : ovf_delay_timer

// ---- hdl/overvoltage_fault_response.sv ----
`timescale 1ns/1ps
module overvoltage_fault_response (
  input  wire logic                        clock,         // System clock, 250 MHz
  input  wire logic                        nrst,          // Async reset, active low
  input  wire logic                        ov_fault,      // Over-voltage detect, synchronous
  input  wire logic [7:0]                  cmd_code,      // Management command code
  input  wire logic                        cmd_wr,        // Write strobe for cmd_code
  input  wire logic [7:0]                  cmd_wr_data,   // Write data byte
  input  wire logic                        status_clear,  // Clear of the fault status bit
  input  wire logic                        clear_all,     // Clear-all-faults command
  input  wire logic                        operation_on,  // On/off from the operation command
  input  wire logic                        ctrl_pin,      // Control pin, asynchronous
  input  wire logic                        other_shutdown,// Another fault shut the unit down
  input  wire logic [ovf_pkg::UNIT_W-1:0]  unit_cycles,   // Delay unit in clock cycles
  output logic [7:0]                       config_q,      // Response word read-back
  output logic                             out_enable,    // Enable toward power stage
  output logic                             restart_req,   // One-cycle restart request
  output logic                             fault_active,  // Fault handling in progress
  output ovf_pkg::ovf_state_e              state_q        // Current controller state
);
  import ovf_pkg::*;

  logic       ctrl_meta_ff;
  logic       ctrl_sync_ff;
  logic       run_cmd_ff;
  logic [2:0] count_ff;
  logic [2:0] nxt_count;
  ovf_state_e nxt_state;
  logic       nxt_restart;
  logic       tmr_start;
  wire  logic tmr_done;

  // Field decode of the response word
  wire logic [1:0] resp_mode  = config_q[RESP_MSB:RESP_LSB];
  wire logic [2:0] retry_code = config_q[RETRY_MSB:RETRY_LSB];
  wire logic [2:0] delay_code = config_q[DELAY_MSB:DELAY_LSB];
  wire logic       cfg_hit    = cmd_wr && (cmd_code == CMD_OV_RESPONSE);

  // Run command and its clear conditions
  wire logic run_cmd   = operation_on && ctrl_sync_ff;
  wire logic run_rise  = run_cmd && !run_cmd_ff;
  wire logic clear_evt = status_clear || clear_all || run_rise;
  wire logic retry_cont = (retry_code == RETRY_CONTINUOUS);
  wire logic retry_left = retry_cont || (count_ff < retry_code);

  // Control pin crosses in through two flops before anything reads it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_meta_ff <= 1'b0;
      ctrl_sync_ff <= 1'b0;
    end else begin
      ctrl_meta_ff <= ctrl_pin;
      ctrl_sync_ff <= ctrl_meta_ff;
    end
  end

  // Response word; reset restores the power-on response
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      config_q <= OV_RESPONSE_RESET;
    end else if (cfg_hit) begin
      config_q <= cmd_wr_data;
    end
  end

  // Delay and retry spacing share one timer; unit length comes in from outside
  ovf_delay_timer u_timer (
    .clock       (clock),
    .nrst        (nrst),
    .start       (tmr_start),
    .unit_cycles (unit_cycles),
    .code        (delay_code),
    .done        (tmr_done)
  );

  // Next state. Off command and other shutdowns outrank the fault response.
  always_comb begin
    nxt_state   = state_q;
    nxt_count   = count_ff;
    nxt_restart = 1'b0;
    tmr_start   = 1'b0;
    if (!run_cmd) begin
      nxt_state = ST_OFF;
      nxt_count = '0;
    end else if (other_shutdown) begin
      nxt_state = ST_LATCH;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          nxt_state = ST_RUN;
          nxt_count = '0;
        end
        ST_RUN: begin
          if (ov_fault) begin
            unique case (resp_mode)
              RESP_IGNORE: begin
                nxt_state = ST_RUN;
              end
              RESP_DELAY: begin
                nxt_state = ST_DELAY;
                tmr_start = 1'b1;
              end
              RESP_DISABLE: begin
                if (retry_code == RETRY_NONE) begin
                  nxt_state = ST_LATCH;
                end else begin
                  nxt_state = ST_WAIT;
                  tmr_start = 1'b1;
                end
              end
              RESP_HOLD_OFF: begin
                nxt_state = ST_HOLD;
              end
            endcase
          end
        end
        ST_DELAY: begin
          if (tmr_done) begin
            if (!ov_fault) begin
              nxt_state = ST_RUN;
            end else if (retry_code == RETRY_NONE) begin
              nxt_state = ST_LATCH;
            end else begin
              nxt_state = ST_WAIT;
              tmr_start = 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (!ov_fault) begin
            nxt_state = ST_RUN;
          end
        end
        ST_WAIT: begin
          if (clear_evt) begin
            nxt_state = ST_RUN;
            nxt_count = '0;
          end else if (tmr_done) begin
            nxt_state   = ST_TRY;
            nxt_restart = 1'b1;
            tmr_start   = 1'b1;
            if (!retry_cont) begin
              nxt_count = count_ff + 3'h1;
            end
          end
        end
        ST_TRY: begin
          if (ov_fault) begin
            if (retry_left) begin
              nxt_state = ST_WAIT;
              tmr_start = 1'b1;
            end else begin
              nxt_state = ST_LATCH;
            end
          end else if (tmr_done) begin
            nxt_state = ST_RUN;                                // Restart held for a full delay
            nxt_count = '0;
          end
        end
        ST_LATCH: begin
          if (clear_evt) begin
            nxt_state = ST_RUN;
            nxt_count = '0;
          end
        end
        default: begin
          nxt_state = ST_LATCH;                                // Unused code fails safe
        end
      endcase
    end
  end

  // State and outputs; enable is registered from the next state so it matches state_q
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q      <= ST_OFF;
      count_ff     <= '0;
      run_cmd_ff   <= 1'b0;
      out_enable   <= 1'b0;
      restart_req  <= 1'b0;
      fault_active <= 1'b0;
    end else begin
      state_q      <= nxt_state;
      count_ff     <= nxt_count;
      run_cmd_ff   <= run_cmd;
      out_enable   <= state_drives(nxt_state);
      restart_req  <= nxt_restart;
      fault_active <= (nxt_state != ST_RUN) && (nxt_state != ST_OFF);
    end
  end

  // Checks: guard means no higher-priority event in the same cycle
  wire logic guard = run_cmd && !other_shutdown;

  a_ignore_keeps_on: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_RUN && resp_mode == RESP_IGNORE && ov_fault)
      |=> (state_q == ST_RUN && out_enable))
    else $error("ignored fault interrupted the output");

  a_delay_runs_on: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_RUN && resp_mode == RESP_DELAY && ov_fault)
      |=> (state_q == ST_DELAY && out_enable))
    else $error("delayed response did not keep converting");

  a_delay_expiry: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_DELAY && tmr_done && ov_fault && retry_code != RETRY_NONE)
      |=> (state_q == ST_WAIT && !out_enable))
    else $error("fault at delay end did not start retry policy");

  a_disable_now: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_RUN && resp_mode == RESP_DISABLE && ov_fault)
      |=> !out_enable)
    else $error("disable response left output enabled");

  a_hold_release: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_HOLD && !ov_fault) |=> (out_enable && state_q == ST_RUN))
    else $error("hold-off did not release when fault went away");

  a_clear_latch: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_LATCH && clear_evt) |=> (state_q == ST_RUN && count_ff == 3'h0))
    else $error("clear event did not release latched fault");

  a_no_retry: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_RUN && resp_mode == RESP_DISABLE && ov_fault
      && retry_code == RETRY_NONE) |=> (state_q == ST_LATCH && !restart_req))
    else $error("zero retry setting did not latch off");

  a_retry_limit: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_TRY && ov_fault && !retry_cont && count_ff >= retry_code)
      |=> (state_q == ST_LATCH && !out_enable))
    else $error("retry limit exceeded");

  a_continuous: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_TRY && ov_fault && retry_cont) |=> (state_q == ST_WAIT))
    else $error("continuous retry stopped");

  a_restart_pulse: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_WAIT && tmr_done && !clear_evt)
      |=> (restart_req && out_enable) ##1 !restart_req)
    else $error("restart request not a single pulse at wait end");

  a_off_stops: assert property (@(posedge clock) disable iff (!nrst)
    (!run_cmd) |=> (state_q == ST_OFF && !out_enable && !restart_req))
    else $error("off command did not stop the output");

  a_delay_waits: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_DELAY && !tmr_done) |=> (state_q == ST_DELAY && out_enable))
    else $error("delay response ended before its time");

  a_hold_stays: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_HOLD && ov_fault) |=> (state_q == ST_HOLD && !out_enable))
    else $error("hold-off released while fault present");

  a_latch_holds: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_LATCH && !clear_evt) |=> (state_q == ST_LATCH && !restart_req))
    else $error("latched fault left without a clear");

  a_count_step: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_WAIT && tmr_done && !clear_evt && !retry_cont)
      |=> (count_ff == $past(count_ff) + 3'h1))
    else $error("restart attempt not counted");

  a_count_frozen: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_WAIT && tmr_done && !clear_evt && retry_cont)
      |=> $stable(count_ff))
    else $error("continuous retry changed the attempt count");

  a_req_in_try: assert property (@(posedge clock) disable iff (!nrst)
    restart_req |-> (state_q == ST_TRY && out_enable))
    else $error("restart request outside a restart attempt");

  a_retry_again: assert property (@(posedge clock) disable iff (!nrst)
    (guard && state_q == ST_TRY && ov_fault && !retry_cont && count_ff < retry_code)
      |=> (state_q == ST_WAIT && !out_enable))
    else $error("failed attempt with retries left did not wait");

  a_shutdown_latch: assert property (@(posedge clock) disable iff (!nrst)
    (run_cmd && other_shutdown) |=> (state_q == ST_LATCH && !out_enable && fault_active))
    else $error("other shutdown did not latch the output off");

  a_enable_follows: assert property (@(posedge clock) disable iff (!nrst)
    out_enable == state_drives(state_q))
    else $error("output enable does not match the state");

endmodule : overvoltage_fault_response

// ---- bench/stage_model.sv ----
`timescale 1ns/1ps
module stage_model (
  input  wire logic       clock,       // System clock
  input  wire logic       nrst,        // Async reset, active low
  input  wire logic       fault_cmd,   // Bench asks for an over-voltage
  input  wire logic       out_enable,  // Enable from the block
  input  wire logic       restart_req, // Restart request from the block
  output logic            ov_fault,    // Comparator result toward the block
  output logic [7:0]      restarts     // Restart requests seen so far
);
  // Comparator result is registered, so the block never sees a fault
  // in the same cycle the bench raises it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ov_fault <= 1'b0;
      restarts <= 8'h00;
    end else begin
      ov_fault <= fault_cmd;
      // A request only counts as a start when the enable comes with it
      if (restart_req && out_enable) restarts <= restarts + 8'h01;
    end
  end
endmodule : stage_model

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import ovf_pkg::*;
  logic clock = 0, nrst = 0, fault_cmd = 0, cmd_wr = 0, status_clear = 0, clear_all = 0;
  logic operation_on = 1, ctrl_pin = 1, other_shutdown = 0, ov_fault, out_enable;
  logic restart_req, fault_active;
  logic [7:0] cmd_code = 8'h00, cmd_wr_data = 8'h00, config_q, restarts, r0;
  logic [15:0] unit_cycles = 16'h0001;
  ovf_state_e state_q;
  int miscompares = 0, checks = 0, cyc = 0, n;

  overvoltage_fault_response i_dut (.clock(clock), .nrst(nrst), .ov_fault(ov_fault),
    .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_wr_data(cmd_wr_data),
    .status_clear(status_clear), .clear_all(clear_all), .operation_on(operation_on),
    .ctrl_pin(ctrl_pin), .other_shutdown(other_shutdown), .unit_cycles(unit_cycles),
    .config_q(config_q), .out_enable(out_enable), .restart_req(restart_req),
    .fault_active(fault_active), .state_q(state_q));
  stage_model i_stage (.clock(clock), .nrst(nrst), .fault_cmd(fault_cmd),
    .out_enable(out_enable), .restart_req(restart_req), .ov_fault(ov_fault),
    .restarts(restarts));

  // 250 MHz clock
  always #2 clock = ~clock;

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // Hang guard, well above the fewer than two thousand cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (e !== g) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    cmd_code = c;
    cmd_wr_data = d;
    cmd_wr = 1;
    tick(1);
    cmd_wr = 0;
    tick(1);
  endtask : wr

  // Bounded wait for a state; running out counts as a mismatch
  task automatic wait_state(input ovf_state_e s, input int lim);
    n = 0;
    while (state_q !== s && n < lim) begin
      n++;
      tick(1);
    end
    chk("state", 8'(s), 8'(state_q));
  endtask : wait_state

  // Drop the fault, then clear the latch with one of the clear events
  task automatic clear_by(input int how);
    fault_cmd = 0;
    tick(3);
    if (how == 0) clear_all = 1;
    else status_clear = 1;
    tick(1);
    clear_all = 0;
    status_clear = 0;
    wait_state(ST_RUN, 10);
  endtask : clear_by

  task automatic t_register;
    chk("reset config", 8'h80, config_q);
    wr(CMD_OV_RESPONSE, 8'h5a);
    chk("config", 8'h5a, config_q);
    wr(8'h42, 8'h00);
    chk("config unmapped", 8'h5a, config_q);
  endtask : t_register

  task automatic t_ignore;
    wr(CMD_OV_RESPONSE, 8'h3f);
    fault_cmd = 1;
    repeat (30) begin
      tick(1);
      chk("enable ignore", 8'h01, 8'(out_enable));
    end
    other_shutdown = 1;
    tick(1);
    other_shutdown = 0;
    wait_state(ST_LATCH, 5);
    clear_by(1);
  endtask : t_ignore

  task automatic t_no_retry;
    wr(CMD_OV_RESPONSE, 8'h80);
    fault_cmd = 1;
    wait_state(ST_LATCH, 4);
    chk("enable off", 8'h00, 8'(out_enable));
    fault_cmd = 0;
    tick(40);
    chk("enable latched", 8'h00, 8'(out_enable));
    chk("fault active", 8'h01, 8'(fault_active));
    operation_on = 0;
    wait_state(ST_OFF, 5);
    operation_on = 1;
    wait_state(ST_RUN, 5);
    chk("enable back", 8'h01, 8'(out_enable));
    chk("fault idle", 8'h00, 8'(fault_active));
  endtask : t_no_retry

  // Permanent fault: each retry code from 1 to 6 gives exactly that many attempts
  task automatic t_counts;
    for (int k = 1; k < 7; k++) begin
      wr(CMD_OV_RESPONSE, {2'b10, 3'(k), 3'h0});
      r0 = restarts;
      fault_cmd = 1;
      tick(150);
      chk("attempts", 8'(k), restarts - r0);
      chk("final state", 8'(ST_LATCH), 8'(state_q));
      clear_by(k % 2);
    end
  endtask : t_counts

  // Spacing of restarts is D+1 cycles of WAIT, D = 2^code * unit
  task automatic t_interval;
    unit_cycles = 16'h0002;
    for (int c = 0; c < 4; c++) begin
      wr(CMD_OV_RESPONSE, {2'b10, 3'h1, 3'(c)});
      fault_cmd = 1;
      wait_state(ST_WAIT, 4);
      n = 0;
      while (state_q === ST_WAIT && n < 100) begin
        n++;
        tick(1);
      end
      chk("wait length", 8'((1 << c) * 2 + 1), 8'(n));
      chk("restart pulse", 8'h01, 8'(restart_req));
      wait_state(ST_LATCH, 40);
      clear_by(0);
    end
  endtask : t_interval

  task automatic t_delay_mode;
    wr(CMD_OV_RESPONSE, 8'h41);
    fault_cmd = 1;
    wait_state(ST_DELAY, 4);
    n = 0;
    while (state_q === ST_DELAY && out_enable === 1'b1 && n < 50) begin
      n++;
      tick(1);
    end
    chk("delay length", 8'h05, 8'(n));
    chk("after delay", 8'(ST_LATCH), 8'(state_q));
    clear_by(0);
  endtask : t_delay_mode

  task automatic t_hold;
    wr(CMD_OV_RESPONSE, 8'hc0);
    fault_cmd = 1;
    wait_state(ST_HOLD, 4);
    tick(20);
    chk("enable hold", 8'h00, 8'(out_enable));
    fault_cmd = 0;
    wait_state(ST_RUN, 5);
    chk("enable resumed", 8'h01, 8'(out_enable));
  endtask : t_hold

  task automatic t_continuous;
    unit_cycles = 16'h0001;
    wr(CMD_OV_RESPONSE, 8'hb8);
    r0 = restarts;
    fault_cmd = 1;
    tick(200);
    chk("many attempts", 8'h01, 8'((restarts - r0) > 8'h06));
    ctrl_pin = 0;
    wait_state(ST_OFF, 6);
    r0 = restarts;
    tick(50);
    chk("attempts stopped", r0, restarts);
    fault_cmd = 0;
    ctrl_pin = 1;
    wait_state(ST_RUN, 6);
  endtask : t_continuous

  initial begin
    tick(20);
    nrst = 1;
    wait_state(ST_RUN, 10);
    t_register();
    t_ignore();
    t_no_retry();
    t_counts();
    t_interval();
    t_delay_mode();
    t_hold();
    t_continuous();
    tally_and_finish();
  end
endmodule : tb
